// ### inc/etcc_pkg.sv
// constants shared by the elapsed time capture counter
package etcc_pkg;
  localparam int unsigned CNT_W        = 40;
  localparam int unsigned DIV_W        = 5;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned SEL_W        = 3;
  localparam logic [7:0]  PIN_FUNC_TEC = 8'h27;
  localparam logic [DIV_W-1:0] DIV_VCO3 = 5'h08;
  localparam logic [DIV_W-1:0] DIV_VCO2 = 5'h14;
  localparam logic [DIV_W-1:0] DIV_ONE  = 5'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
  localparam logic        VCOSEL_VCO3  = 1'b0;
  localparam logic        TRIG_PIN     = 1'b1;
  localparam logic        CLR_NORMAL   = 1'b0;
  localparam logic [SEL_W-1:0] BYTE_LSB = 3'h0;
  localparam logic [SEL_W-1:0] BYTE_MSB = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 40'h00_0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 40'h00_0000_0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 40'hff_ffff_ffff;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage

// ### src/etcc_counter.sv
// elapsed time capture counter with serial and pin triggers
`timescale 1ns/10ps
`default_nettype none

// How it works
// [RULE1] serial mode, enabled and armed: chip-select falling edge captures count
// [RULE2] reading the capture MSB blocks chip-select captures until LSB is read
// [RULE3] capture and re-arm may both happen inside one multibyte read
// [RULE4] pin with function code 0x27 captures count on its programmed edge
// [RULE5] after a pin capture, later pin edges are ignored until LSB read
// [RULE6] trigger select 1 picks the pin trigger, 0 picks chip-select falls
// [RULE7] source select 0: count clock is third VCO divided by 8
// [RULE8] source select 1: count clock is second VCO divided by 20
// [RULE9] clear control 0 lets the counter run normally
// [RULE10] host keeps pin rise 10 ns from enabling edge, holds it 10 ns
// [RULE11] host waits 1 us after LSB read before a new pin trigger
// [RULE12] counter counts up every count tick, wrapping from 2^40-1 to 0
// [RULE13] enable 0 holds count at zero; counting restarts from zero
// [RULE14] host software detects wrap, resets by toggling enable
// [RULE15] source select also steers the reference validators' VCO choice
// [RULE16] captured count is read as five byte-wide registers
// [RULE17] all 40 bits are latched together in one cycle
module etcc_counter
  import etcc_pkg::*;
(
  input  wire logic              ref_clk,               // 250 MHz clock
  input  wire logic              nrst,                  // async reset, low
  input  wire logic              counter_enable_bit,    // 1 runs the counter
  input  wire logic              trigger_source_select, // 1 pin, 0 serial
  input  wire logic              counter_clear_control, // 0 normal run
  input  wire logic              vco_source_select,     // 0 vco3/8, 1 vco2/20
  input  wire logic [7:0]        pin_function_code,     // pin mode code
  input  wire logic              pin_polarity_invert,   // 1 falling edge
  input  wire logic              trig_pin,              // trigger pin, async
  input  wire logic              serial_chip_select_n,  // chip select, async
  input  wire logic              vco3_pulse,            // one per vco3 cycle
  input  wire logic              vco2_pulse,            // one per vco2 cycle
  input  wire logic              rd_strobe,             // byte read pulse
  input  wire logic [SEL_W-1:0]  rd_byte_sel,           // 0 lsb .. 4 msb
  output logic [BYTE_W-1:0]      rd_data,               // read byte
  output logic [CNT_W-1:0]       capture_value,         // captured count
  output logic [CNT_W-1:0]       running_count,         // live count
  output logic                   capture_locked,        // 1 captures blocked
  output logic                   count_tick,            // count clock enable
  output logic                   validator_vco_sel      // validators' vco
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [DIV_W-1:0] div_last(input logic sel);
    div_last = (sel == VCOSEL_VCO3) ? DIV_VCO3 - DIV_ONE
                                    : DIV_VCO2 - DIV_ONE;
  endfunction

  function automatic logic [BYTE_W-1:0] pick_byte(
    input logic [CNT_W-1:0] v,
    input logic [SEL_W-1:0] s
  );
    pick_byte = BYTE_ZERO;
    if (s <= BYTE_MSB) begin
      pick_byte = v[s*BYTE_W +: BYTE_W];
    end
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pin_sync_r;
  logic [1:0] cs_sync_r;
  logic       pin_lvl_r;
  logic       cs_lvl_r;
  logic [1:0] pin_sync_nxt;
  logic [1:0] cs_sync_nxt;
  logic       pin_act;
  logic       pin_edge;
  logic       cs_fall;

  always_comb begin
    pin_sync_nxt = {pin_sync_r[0], trig_pin};
    cs_sync_nxt  = {cs_sync_r[0], serial_chip_select_n};
    // polarity invert turns a falling edge into an active rise
    pin_act  = pin_sync_r[1] ^ pin_polarity_invert;
    pin_edge = pin_act & ~pin_lvl_r;
    cs_fall  = ~cs_sync_r[1] & cs_lvl_r;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_r <= 2'h0;
      cs_sync_r  <= 2'h3;
      pin_lvl_r  <= 1'b0;
      cs_lvl_r   <= 1'b1;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      cs_sync_r  <= cs_sync_nxt;
      pin_lvl_r  <= pin_act;
      cs_lvl_r   <= cs_sync_r[1];
    end
  end

  // ****************************************
  // count clock divider
  // ****************************************
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic             tick_r;
  logic             tick_nxt;
  logic             vco_pulse;
  logic             vsel_r;

  always_comb begin
    vco_pulse = (vco_source_select == VCOSEL_VCO3) ? vco3_pulse   // RULE7
                                                   : vco2_pulse;  // RULE8
    div_nxt  = div_r;
    tick_nxt = 1'b0;
    if (vco_pulse) begin
      if (div_r >= div_last(vco_source_select)) begin
        div_nxt  = DIV_ZERO;
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + DIV_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= DIV_ZERO;
      tick_r <= 1'b0;
      vsel_r <= VCOSEL_VCO3;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
      // a change here may briefly disqualify references downstream
      vsel_r <= vco_source_select;  // RULE15
    end
  end

  // ****************************************
  // running counter
  // ****************************************
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             run;

  always_comb begin
    run     = counter_enable_bit & (counter_clear_control == CLR_NORMAL);
    cnt_nxt = cnt_r;
    if (!run) begin
      cnt_nxt = CNT_ZERO;  // RULE13
    end else if (tick_r) begin
      cnt_nxt = cnt_r + CNT_ONE;  // RULE9 RULE12
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= CNT_ZERO;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // capture and arming
  // ****************************************
  logic [CNT_W-1:0]  cap_r;
  logic [CNT_W-1:0]  cap_nxt;
  logic              lock_r;
  logic              lock_nxt;
  logic [BYTE_W-1:0] rd_r;
  logic [BYTE_W-1:0] rd_nxt;
  logic              pin_mode;
  logic              spi_cap;
  logic              pin_cap;
  logic              rd_lsb;
  logic              rd_msb;

  always_comb begin
    pin_mode = (trigger_source_select == TRIG_PIN);  // RULE6
    spi_cap  = counter_enable_bit & ~pin_mode & cs_fall & ~lock_r;  // RULE1
    pin_cap  = counter_enable_bit & pin_mode & ~lock_r & pin_edge
             & (pin_function_code == PIN_FUNC_TEC);  // RULE4
    rd_lsb   = rd_strobe & (rd_byte_sel == BYTE_LSB);
    rd_msb   = rd_strobe & (rd_byte_sel == BYTE_MSB);
    cap_nxt  = cap_r;
    if (spi_cap | pin_cap) begin
      cap_nxt = cnt_r;  // RULE17
    end
    // blocking wins over re-arm when both land in one cycle
    lock_nxt = lock_r;
    if (rd_lsb) begin
      lock_nxt = 1'b0;  // RULE3
    end
    if ((rd_msb & ~pin_mode) | pin_cap) begin
      lock_nxt = 1'b1;  // RULE2 RULE5
    end
    rd_nxt = rd_r;
    if (rd_strobe) begin
      rd_nxt = pick_byte(cap_r, rd_byte_sel);  // RULE16
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_r  <= CNT_ZERO;
      lock_r <= 1'b0;
      rd_r   <= BYTE_ZERO;
    end else begin
      cap_r  <= cap_nxt;
      lock_r <= lock_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign rd_data           = rd_r;
  assign capture_value     = cap_r;
  assign running_count     = cnt_r;
  assign capture_locked    = lock_r;
  assign count_tick        = tick_r;
  assign validator_vco_sel = vsel_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_spi_capture;
    counter_enable_bit && !trigger_source_select && cs_fall && !lock_r
      |=> capture_value == $past(cnt_r);
  endproperty
  a_spi_capture: assert property (p_spi_capture)  // RULE1
    else $error("chip-select fall did not capture the count");

  property p_locked_hold;
    lock_r |=> $stable(capture_value);
  endproperty
  a_locked_hold: assert property (p_locked_hold)  // RULE2
    else $error("capture changed while blocked");

  property p_rearm;
    rd_lsb && !rd_msb && !pin_cap |=> !capture_locked;
  endproperty
  a_rearm: assert property (p_rearm)  // RULE3
    else $error("lsb read did not re-arm capture");

  property p_pin_capture;
    pin_cap |=> capture_value == $past(cnt_r) && capture_locked;
  endproperty
  a_pin_capture: assert property (p_pin_capture)  // RULE4
    else $error("pin edge did not capture and block");

  property p_pin_block;
    pin_cap ##1 (!rd_lsb)[*2] |-> $stable(capture_value);
  endproperty
  a_pin_block: assert property (p_pin_block)  // RULE5
    else $error("pin edge updated a blocked capture");

  property p_wrap;
    run && tick_r && cnt_r == CNT_MAX ##1 run |-> running_count == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)  // RULE12
    else $error("counter did not wrap to zero");

  property p_hold_zero;
    !counter_enable_bit |=> running_count == CNT_ZERO;
  endproperty
  a_hold_zero: assert property (p_hold_zero)  // RULE13
    else $error("disabled counter not at zero");

  property p_count_step;
    run && tick_r |=> running_count == $past(cnt_r) + CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step)  // RULE9
    else $error("running counter did not step by one");

  property p_src_sel;
    trigger_source_select && cs_fall && !pin_edge |=> $stable(capture_value);
  endproperty
  a_src_sel: assert property (p_src_sel)  // RULE6
    else $error("chip-select fall captured in pin mode");

  property p_div_tick;
    count_tick |-> $past(div_r) == div_last($past(vco_source_select));
  endproperty
  a_div_tick: assert property (p_div_tick)  // RULE7
    else $error("count tick at wrong divider phase");

  property p_vsel;
    ##1 validator_vco_sel == $past(vco_source_select);
  endproperty
  a_vsel: assert property (p_vsel)  // RULE15
    else $error("validator vco select does not follow");

  c_spi_capture: cover property (spi_cap);
  c_pin_capture: cover property (pin_cap ##[1:50] rd_lsb);
  c_wrap: cover property (run && tick_r && cnt_r == CNT_MAX);
  c_vco2_tick: cover property (vco_source_select && count_tick);

endmodule

`default_nettype wire

// ### tb/etcc_host_model.sv
// host side model: chip select, trigger pin and vco pulse sources
`timescale 1ns/10ps
`default_nettype none
module etcc_host_model (
  input  wire logic ref_clk,              // bench clock
  output logic      serial_chip_select_n, // chip select, idle high
  output logic      trig_pin,             // trigger pin
  output logic      vco3_pulse,           // vco3 cycle pulse
  output logic      vco2_pulse            // vco2 cycle pulse
);
  initial begin
    serial_chip_select_n = 1'b1;
    trig_pin = 1'b0;
    vco3_pulse = 1'b0;
    vco2_pulse = 1'b0;
  end
  // one vco cycle per clock from the chosen source, then quiet
  task automatic vco(input logic s, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      vco2_pulse <= s;
      vco3_pulse <= ~s;
    end
    @(posedge ref_clk);
    vco2_pulse <= 1'b0;
    vco3_pulse <= 1'b0;
  endtask
  // short frame; ends off the edge so callers sample settled values
  task automatic cs_frame();
    @(posedge ref_clk);
    serial_chip_select_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    serial_chip_select_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  // level held 24 ns, beyond the 10 ns minimum
  task automatic pin(input logic v);
    @(posedge ref_clk);
    trig_pin <= v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ### tb/etcc_counter_tb_top.sv
// self-checking bench for the elapsed time capture counter
`timescale 1ns/10ps
`default_nettype none
module etcc_counter_tb_top;
  import etcc_pkg::*;
  logic ref_clk, nrst, en, tsel, vsel, pol, rds, lock, vsel_o, cs_n, tp, v3;
  logic v2, clr, tick;
  logic [7:0] fcode, rdd;
  logic [SEL_W-1:0] rsel;
  logic [CNT_W-1:0] cap, run;
  logic [CNT_W-1:0] ticks = CNT_ZERO;
  int num_errors = 0;
  int checked = 0;
  // ****************************************
  // instances
  // ****************************************
  etcc_host_model etcc_host_model_i (.ref_clk(ref_clk),
    .serial_chip_select_n(cs_n), .trig_pin(tp), .vco3_pulse(v3),
    .vco2_pulse(v2));
  etcc_counter etcc_counter_i (.ref_clk(ref_clk), .nrst(nrst),
    .counter_enable_bit(en), .trigger_source_select(tsel),
    .counter_clear_control(clr), .vco_source_select(vsel),
    .pin_function_code(fcode), .pin_polarity_invert(pol), .trig_pin(tp),
    .serial_chip_select_n(cs_n), .vco3_pulse(v3), .vco2_pulse(v2),
    .rd_strobe(rds), .rd_byte_sel(rsel), .rd_data(rdd),
    .capture_value(cap), .running_count(run), .capture_locked(lock),
    .count_tick(tick), .validator_vco_sel(vsel_o));
  // counts count clock ticks seen on the design's output
  always @(posedge ref_clk) begin
    if (tick === 1'b1) ticks <= ticks + CNT_ONE;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [SEL_W-1:0] s, input logic [7:0] e);
    @(posedge ref_clk);
    rds <= 1'b1;
    rsel <= s;
    @(posedge ref_clk);
    rds <= 1'b0;
    #1 chk({32'h0, rdd}, {32'h0, e});
  endtask
  // bounded wait for the lock flag; a miss ends the run
  task automatic wlock(input logic v);
    int i;
    for (i = 0; i < 10 && lock !== v; i++) cyc(1);
    if (lock !== v) begin
      num_errors++;
      end_sim();
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_serial();
    etcc_host_model_i.vco(1'b0, 24);
    cyc(4);
    chk(run, 40'h3);
    etcc_host_model_i.cs_frame();
    chk(cap, 40'h3);
    rd(3'h0, 8'h03);
    for (int i = 1; i < 5; i++) rd(i[2:0], 8'h00);
    chk({39'h0, lock}, 40'h1);
    etcc_host_model_i.vco(1'b0, 8);
    etcc_host_model_i.cs_frame();
    chk(cap, 40'h3);
    rd(3'h0, 8'h03);
    etcc_host_model_i.cs_frame();
    chk(cap, 40'h4);
  endtask
  task automatic t_pin();
    @(posedge ref_clk);
    tsel <= TRIG_PIN;
    fcode <= PIN_FUNC_TEC;
    etcc_host_model_i.vco(1'b0, 8);
    etcc_host_model_i.cs_frame();
    chk(cap, 40'h4);
    etcc_host_model_i.pin(1'b1);
    wlock(1'b1);
    chk(cap, 40'h5);
    etcc_host_model_i.vco(1'b0, 8);
    etcc_host_model_i.pin(1'b0);
    etcc_host_model_i.pin(1'b1);
    chk(cap, 40'h5);
    rd(3'h0, 8'h05);
    cyc(250);
    etcc_host_model_i.pin(1'b0);
    @(posedge ref_clk);
    fcode <= 8'h26;
    etcc_host_model_i.pin(1'b1);
    chk(cap, 40'h5);
    @(posedge ref_clk);
    pol <= 1'b1;
    cyc(3);
    @(posedge ref_clk);
    fcode <= PIN_FUNC_TEC;
    etcc_host_model_i.pin(1'b0);
    chk(cap, 40'h6);
  endtask
  task automatic t_vco2();
    @(posedge ref_clk);
    vsel <= 1'b1;
    etcc_host_model_i.vco(1'b1, 20);
    cyc(4);
    chk(run, 40'h7);
    chk({39'h0, vsel_o}, 40'h1);
    chk(ticks, 40'h7);
  endtask
  task automatic t_off();
    @(posedge ref_clk);
    en <= 1'b0;
    etcc_host_model_i.vco(1'b1, 40);
    cyc(3);
    chk(run, 40'h0);
    @(posedge ref_clk);
    en <= 1'b1;
    cyc(3);
    chk(run, 40'h0);
    etcc_host_model_i.vco(1'b1, 20);
    cyc(4);
    chk(run, 40'h1);
    @(posedge ref_clk);
    clr <= 1'b1;
    etcc_host_model_i.vco(1'b1, 20);
    cyc(3);
    chk(run, 40'h0);
    @(posedge ref_clk);
    clr <= CLR_NORMAL;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
  initial begin
    {nrst, tsel, vsel, pol, rds} = '0;
    en = 1'b1;
    clr = CLR_NORMAL;
    fcode = 8'h00;
    rsel = BYTE_LSB;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(2);
    t_serial();
    t_pin();
    t_vco2();
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
